/* File: hdl/rcs_regs.svh */
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define RCS_ADR_W 8
`define RCS_CFG_ADDR 8'h00
`define RCS_STAT_ADDR 8'h04
`define RCS_CFG_RESET 16'h0028
`define RCS_CFG_LOAD_BIT 15
`define RCS_CFG_WR_MASK 16'h7FFF
`define RCS_DAT_ZERO 32'h0000_0000
`define RCS_HI_ZERO 16'h0000

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define RCS_ST_MODE 0
`define RCS_ST_PORT_LO 1
`define RCS_ST_PORT_HI 2
`define RCS_ST_D21 3
`define RCS_ST_D2524_LO 4
`define RCS_ST_D2524_HI 5
`define RCS_ST_CLK_LO 6
`define RCS_ST_CLK_HI 7
`define RCS_ST_CFG_EN 8
`define RCS_ST_PAD 7'h00

// ----------------------------------------
// Defaults when overrides are off
// ----------------------------------------
`define RCS_DEF_MODE 1'h1
`define RCS_DEF_PORT 2'h3
`define RCS_DEF_D21 1'h0
`define RCS_DEF_D2524 2'h0

// ----------------------------------------
// Synchronised pin vector layout
// ----------------------------------------
`define RCS_P_D16 0
`define RCS_P_D19 1
`define RCS_P_D20 2
`define RCS_P_D21 3
`define RCS_P_D24 4
`define RCS_P_D25 5
`define RCS_P_CFG_EN 6
`define RCS_P_CLK0 7
`define RCS_P_CLK1 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define RCS_CLK_MHZ 25
`define RCS_RST_OUT_NS 1000
`define RCS_HOLD_CYC ((`RCS_RST_OUT_NS * `RCS_CLK_MHZ + 999) / 1000)
`define RCS_CNT_ZERO 8'h00

`endif

/* File: hdl/rcs_pkg.sv */
package rcs_pkg;
  typedef enum logic {RCS_ST_HOLD, RCS_ST_RUN} rcs_state_t;
  typedef logic [8:0] rcs_pins_t;
  typedef logic [15:0] rcs_word16_t;
  typedef logic [7:0] rcs_cnt_t;
endpackage

/* File: hdl/rcs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire rcs_pkg::rcs_pins_t pin_i,
  output var rcs_pkg::rcs_pins_t pin_o
);
  import rcs_pkg::*;

  typedef struct packed {
    rcs_pins_t s1;
    rcs_pins_t s2;
    rcs_pins_t s3;
    rcs_pins_t stb;
  } rcs_sync_t;

  rcs_sync_t sync_reg;
  rcs_sync_t sync_next;
  rcs_pins_t agreed;

  // ----------------------------------------
  // Accept a level once stages two and three agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < $bits(rcs_pins_t); i++) begin : g_bit
      assign agreed[i] = (sync_reg.s2[i] == sync_reg.s3[i]) ? sync_reg.s2[i] : sync_reg.stb[i];
    end
  endgenerate

  always_comb begin
    sync_next = sync_reg;
    if (ce_i) begin
      sync_next.s1 = pin_i;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      sync_next.stb = agreed;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign pin_o = sync_reg.stb;
endmodule // rcs_sync
`default_nettype wire

/* File: hdl/rcs_wb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"
module rcs_wb (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`RCS_ADR_W-1:0] adr_i,
  input wire rcs_pkg::rcs_word16_t cfg_i,
  input wire rcs_pkg::rcs_word16_t stat_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] dat_o,
  output logic wr_cfg_o
);
  import rcs_pkg::*;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] dat;
  } rcs_wb_t;

  rcs_wb_t wb_reg;
  rcs_wb_t wb_next;
  logic req;

  assign req = cyc_i && stb_i && !wb_reg.ack && !wb_reg.err;

  // ----------------------------------------
  // Decode; answer one cycle after the request
  // ----------------------------------------
  always_comb begin
    wb_next = wb_reg;
    if (ce_i) begin
      wb_next.ack = 1'b0;
      wb_next.err = 1'b0;
      if (req && adr_i == `RCS_CFG_ADDR) begin
        wb_next.ack = 1'b1;
        wb_next.dat = {`RCS_HI_ZERO, cfg_i};
      end else if (req && adr_i == `RCS_STAT_ADDR) begin
        wb_next.ack = 1'b1;
        wb_next.dat = {`RCS_HI_ZERO, stat_i};
      end else if (req) begin
        wb_next.err = 1'b1;
        wb_next.dat = `RCS_DAT_ZERO;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_reg <= '0;
    end else begin
      wb_reg <= wb_next;
    end
  end

  // Write lands on the edge where the master sees ack
  assign wr_cfg_o = cyc_i && stb_i && we_i && wb_reg.ack && adr_i == `RCS_CFG_ADDR;
  assign ack_o = wb_reg.ack;
  assign err_o = wb_reg.err;
  assign dat_o = wb_reg.dat;
endmodule // rcs_wb
`default_nettype wire

/* File: hdl/rcs_top.sv */
// What this block does
// - Config register resets 0x0028, load bit reserved
// - Status register bits are read-only
// - Overrides only D25:24, D21:19, D16
// - Other data pins never affect results
// - D16 high selects master mode, default
// - D16 low with enable gives reserved mode
// - D26 and D17 ignored for mode
// - Clock-mode pins ignored after reset ends
// - Mode bit lives in status register
// - Boot port size from D20:19 at negation
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"
module rcs_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`RCS_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [31:0] data_pins_i,
  input wire logic reset_config_enable_i,
  input wire logic [1:0] clock_mode_select_pins_i,
  output logic reset_output_n_o,
  output logic chip_mode_o,
  output logic [1:0] boot_chip_select_size_o,
  output logic [1:0] clock_mode_o,
  output logic [2:0] override_misc_o,
  output rcs_pkg::rcs_word16_t chip_config_o
);
  import rcs_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    rcs_state_t state;
    rcs_cnt_t cnt;
    logic rst_out_n;
    rcs_word16_t cfg;
    logic mode;
    logic [1:0] port;
    logic d21;
    logic [1:0] d2524;
    logic [1:0] clk_sel;
    logic cfg_en_seen;
  } rcs_main_t;

  localparam rcs_main_t RST_VAL = '{
    state: RCS_ST_HOLD,
    cnt: rcs_cnt_t'(`RCS_HOLD_CYC - 1),
    rst_out_n: 1'b0,
    cfg: `RCS_CFG_RESET,
    mode: `RCS_DEF_MODE,
    port: `RCS_DEF_PORT,
    d21: `RCS_DEF_D21,
    d2524: `RCS_DEF_D2524,
    clk_sel: 2'h0,
    cfg_en_seen: 1'b0
  };

  rcs_main_t main_reg;
  rcs_main_t main_next;
  rcs_pins_t pins_raw;
  rcs_pins_t pins;
  rcs_word16_t stat_word;
  rcs_word16_t wr_mask;
  logic wr_cfg;
  logic capture;
  logic cfg_en_on;

  // ----------------------------------------
  // Pin gathering
  // ----------------------------------------
  // Only the override pins are wired in; the rest of the bus stays unread
  // Unsampled data pins cannot reach any result
  always_comb begin
    pins_raw = '0;
    pins_raw[`RCS_P_D16] = data_pins_i[16];
    pins_raw[`RCS_P_D19] = data_pins_i[19];
    pins_raw[`RCS_P_D20] = data_pins_i[20];
    pins_raw[`RCS_P_D21] = data_pins_i[21];
    pins_raw[`RCS_P_D24] = data_pins_i[24];
    pins_raw[`RCS_P_D25] = data_pins_i[25];
    pins_raw[`RCS_P_CFG_EN] = reset_config_enable_i;
    pins_raw[`RCS_P_CLK0] = clock_mode_select_pins_i[0];
    pins_raw[`RCS_P_CLK1] = clock_mode_select_pins_i[1];
  end

  rcs_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(pins_raw),
    .pin_o(pins)
  );

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  rcs_wb u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cyc_i(wb_cyc_i),
    .stb_i(wb_stb_i),
    .we_i(wb_we_i),
    .adr_i(wb_adr_i),
    .cfg_i(main_reg.cfg),
    .stat_i(stat_word),
    .ack_o(wb_ack_o),
    .err_o(wb_err_o),
    .dat_o(wb_dat_o),
    .wr_cfg_o(wr_cfg)
  );

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // No write path reaches these bits
  always_comb begin
    stat_word = {
      `RCS_ST_PAD,
      main_reg.cfg_en_seen,
      main_reg.clk_sel,
      main_reg.d2524,
      main_reg.d21,
      main_reg.port,
      main_reg.mode
    };
  end

  // Load bit excluded from the mask so it always reads zero
  assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & `RCS_CFG_WR_MASK;

  assign cfg_en_on = pins[`RCS_P_CFG_EN];

  // ----------------------------------------
  // Reset sequencing and capture
  // ----------------------------------------
  always_comb begin
    main_next = main_reg;
    capture = 1'b0;
    if (ce_i) begin
      case (main_reg.state)
        RCS_ST_HOLD: begin
          if (main_reg.cnt == `RCS_CNT_ZERO) begin
            main_next.state = RCS_ST_RUN;
            main_next.rst_out_n = 1'b1;
            capture = 1'b1;
            // Clock mode has no default; pins are taken as driven
            main_next.clk_sel = {pins[`RCS_P_CLK1], pins[`RCS_P_CLK0]};
            main_next.cfg_en_seen = cfg_en_on;
            if (cfg_en_on) begin
              main_next.mode = pins[`RCS_P_D16];
              main_next.port = {pins[`RCS_P_D20], pins[`RCS_P_D19]};
              main_next.d21 = pins[`RCS_P_D21];
              main_next.d2524 = {pins[`RCS_P_D25], pins[`RCS_P_D24]};
            end else begin
              main_next.mode = `RCS_DEF_MODE;
              main_next.port = `RCS_DEF_PORT;
              main_next.d21 = `RCS_DEF_D21;
              main_next.d2524 = `RCS_DEF_D2524;
            end
          end else begin
            main_next.cnt = main_reg.cnt - 8'h01;
          end
        end
        RCS_ST_RUN: begin
          // Results frozen until the next reset; pins no longer looked at
          main_next.clk_sel = main_reg.clk_sel;
        end
        default: begin
          main_next.state = RCS_ST_HOLD;
        end
      endcase
      if (wr_cfg) begin
        main_next.cfg = (main_reg.cfg & ~wr_mask) | (wb_dat_i[15:0] & wr_mask);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_reg <= RST_VAL;
    end else begin
      main_reg <= main_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reset_output_n_o = main_reg.rst_out_n;
  assign chip_mode_o = main_reg.mode;
  assign boot_chip_select_size_o = main_reg.port;
  assign clock_mode_o = main_reg.clk_sel;
  assign override_misc_o = {main_reg.d2524, main_reg.d21};
  assign chip_config_o = main_reg.cfg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_cap_on;
    capture && cfg_en_on;
  endsequence

  sequence s_cap_off;
    capture && !cfg_en_on;
  endsequence

  sequence s_stat_write;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `RCS_STAT_ADDR;
  endsequence

  chk_cfg_reset_value: assert property (
    $past(rst_i) |-> main_reg.cfg == `RCS_CFG_RESET)
    else $error("config register reset value wrong");

  chk_load_bit_zero: assert property (
    !main_reg.cfg[`RCS_CFG_LOAD_BIT])
    else $error("reserved load bit became set");

  chk_status_readonly: assert property (
    s_stat_write |=> $stable(stat_word))
    else $error("status word changed by a write");

  chk_override_upper: assert property (
    s_cap_on |=> main_reg.d2524 == $past({pins[`RCS_P_D25], pins[`RCS_P_D24]})
      && main_reg.d21 == $past(pins[`RCS_P_D21]))
    else $error("upper override pins not captured");

  chk_mode_master: assert property (
    s_cap_on ##0 pins[`RCS_P_D16] |=> chip_mode_o && stat_word[`RCS_ST_MODE])
    else $error("master mode not selected");

  chk_mode_reserved: assert property (
    s_cap_on ##0 !pins[`RCS_P_D16] |=> !chip_mode_o ##1 !chip_mode_o)
    else $error("reserved mode not entered");

  chk_port_size: assert property (
    s_cap_on |=> $rose(reset_output_n_o)
      && boot_chip_select_size_o == $past({pins[`RCS_P_D20], pins[`RCS_P_D19]}))
    else $error("boot port size not taken at negation");

  chk_defaults_used: assert property (
    s_cap_off |=> chip_mode_o == `RCS_DEF_MODE
      && boot_chip_select_size_o == `RCS_DEF_PORT && !main_reg.cfg_en_seen)
    else $error("defaults not applied with enable off");

  chk_clk_sel_frozen: assert property (
    main_reg.state == RCS_ST_RUN |=> $stable(clock_mode_o) [*2])
    else $error("clock mode changed after reset");

  chk_reset_output_state: assert property (
    reset_output_n_o == (main_reg.state == RCS_ST_RUN))
    else $error("reset output disagrees with sequencer");

  // ----------------------------------------
  // Bus and sequencing checks
  // ----------------------------------------
  sequence s_good_req;
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
      && (wb_adr_i == `RCS_CFG_ADDR || wb_adr_i == `RCS_STAT_ADDR);
  endsequence

  sequence s_bad_req;
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
      && wb_adr_i != `RCS_CFG_ADDR && wb_adr_i != `RCS_STAT_ADDR;
  endsequence

  chk_reset_outputs: assert property (
    $past(rst_i) |-> !reset_output_n_o && chip_config_o == `RCS_CFG_RESET
      && chip_mode_o == `RCS_DEF_MODE && !wb_ack_o && !wb_err_o)
    else $error("outputs not at reset values after reset");

  chk_release_low: assert property (
    $past(rst_i) |-> !reset_output_n_o ##1 !reset_output_n_o)
    else $error("reset output rose too soon after release");

  chk_capture_once: assert property (
    capture |=> !capture)
    else $error("pins captured twice in one reset");

  chk_clk_sel_taken: assert property (
    capture |=> clock_mode_o == $past({pins[`RCS_P_CLK1], pins[`RCS_P_CLK0]}))
    else $error("clock mode not taken at negation");

  // Pins keep moving once the bus carries traffic; results must not follow
  chk_pins_ignored: assert property (
    main_reg.state == RCS_ST_RUN && $changed(pins) |=> $stable(chip_mode_o)
      && $stable(boot_chip_select_size_o) && $stable(override_misc_o))
    else $error("results followed pins after reset");

  chk_misc_default: assert property (
    s_cap_off |=> override_misc_o == {`RCS_DEF_D2524, `RCS_DEF_D21})
    else $error("override defaults not applied");

  chk_stat_en_bit: assert property (
    s_cap_on |=> stat_word[`RCS_ST_CFG_EN])
    else $error("enable seen bit not set");

  chk_ack_mapped: assert property (
    s_good_req |=> wb_ack_o && !wb_err_o)
    else $error("mapped request not acknowledged");

  chk_err_unmapped: assert property (
    s_bad_req |=> wb_err_o && !wb_ack_o && wb_dat_o == `RCS_DAT_ZERO)
    else $error("unmapped request not refused");

  chk_ack_pulse: assert property (
    wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  chk_cfg_nowrite: assert property (
    !wr_cfg && ce_i |=> $stable(chip_config_o))
    else $error("config register changed without a write");

  // Mode lives in the status word, so a config write must leave it alone
  chk_write_keeps_mode: assert property (
    wr_cfg |=> $stable(chip_mode_o))
    else $error("config write moved chip mode");
endmodule // rcs_top
`default_nettype wire

/* File: hdl/rcs_top_end.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: test/rcs_strap_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_strap_model (
  input wire logic reset_output_n_i,
  input wire logic [31:0] pat_i,
  input wire logic en_i,
  input wire logic [1:0] clk_sel_i,
  output logic [31:0] data_pins_o,
  output logic reset_config_enable_o,
  output logic [1:0] clock_mode_select_pins_o
);
  // Straps hold the bus only in reset; afterwards the bus carries other traffic
  assign data_pins_o = reset_output_n_i ? ~pat_i : pat_i;
  assign reset_config_enable_o = en_i;
  // No default clock mode exists, so the pins are always driven
  assign clock_mode_select_pins_o = clk_sel_i;
endmodule // rcs_strap_model
`default_nettype wire

/* File: test/reset_config_sampler_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"
module reset_config_sampler_tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, en = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, pat = 32'h0, rdat, data_pins, dat_o;
  logic [1:0] cm = 2'h0, clk_pins, bsize, cmode;
  logic cfg_en, ack, err, rst_n, mode, rerr;
  logic [2:0] misc;
  logic [15:0] cfg_word;
  int bad_count = 0, n_compared = 0, cycles = 0;

  initial forever #20 clk_i = ~clk_i;

  rcs_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .data_pins_i(data_pins), .reset_config_enable_i(cfg_en),
    .clock_mode_select_pins_i(clk_pins), .reset_output_n_o(rst_n), .chip_mode_o(mode),
    .boot_chip_select_size_o(bsize), .clock_mode_o(cmode), .override_misc_o(misc),
    .chip_config_o(cfg_word));

  rcs_strap_model strap (.reset_output_n_i(rst_n), .pat_i(pat), .en_i(en), .clk_sel_i(cm),
    .data_pins_o(data_pins), .reset_config_enable_o(cfg_en), .clock_mode_select_pins_o(clk_pins));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Classic single cycle; held until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && err !== 1'h1 && n < 50);
    rdat = dat_o;
    rerr = err;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic cfg(input logic [31:0] p, input logic e, input logic [1:0] c);
    int n = 0;
    logic [2:0] m;
    logic [1:0] bs;
    logic md;
    logic [31:0] s;
    m = e ? {p[25], p[24], p[21]} : 3'h0;
    bs = e ? p[20:19] : 2'h3;
    md = e ? p[16] : 1'h1;
    s = {23'h0, e, c, m, bs, md};
    @(posedge clk_i);
    pat <= p;
    en <= e;
    cm <= c;
    rst_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rst_n !== 1'h1 && n < 100);
    check("reset output", 32'(rst_n), 32'h1);
    check("chip mode", 32'(mode), 32'(md));
    check("boot size", 32'(bsize), 32'(bs));
    check("override misc", 32'(misc), 32'(m));
    check("clock mode", 32'(cmode), 32'(c));
    check("config reset", 32'(cfg_word), 32'h28);
    wb(1'h0, `RCS_STAT_ADDR, 32'h0);
    check("status", rdat, s);
    cm <= ~c;
    repeat (6) @(posedge clk_i);
    check("clock mode held", 32'(cmode), 32'(c));
    wb(1'h1, `RCS_STAT_ADDR, 32'h0000_FFFF);
    wb(1'h0, `RCS_STAT_ADDR, 32'h0);
    check("status read only", rdat, s);
  endtask

  task automatic regs;
    wb(1'h0, `RCS_CFG_ADDR, 32'h0);
    check("config read", rdat, 32'h28);
    wb(1'h1, `RCS_CFG_ADDR, 32'h0000_FFFF);
    wb(1'h0, `RCS_CFG_ADDR, 32'h0);
    check("config load bit", rdat, 32'h7FFF);
    check("config port", 32'(cfg_word), 32'h7FFF);
    wb(1'h0, 8'h08, 32'h0);
    check("unmapped err", 32'(rerr), 32'h1);
    check("unmapped data", rdat, 32'h0);
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      stop_test;
    end
  end

  initial begin
    cfg(32'h0231_0000, 1'h1, 2'h0);
    // Every non-override pin inverted, D26 and D17 included
    cfg(32'h0231_0000 ^ ~32'h0339_0000, 1'h1, 2'h1);
    cfg(32'hFFFE_FFFF, 1'h1, 2'h2);
    regs;
    cfg(32'h0000_0000, 1'h0, 2'h3);
    stop_test;
  end
endmodule // reset_config_sampler_tb
`default_nettype wire
